// ===== src/mac_arith.sv
// Combinational multiply/accumulate core of the multiply/accumulate unit.
// Assumes operands and accumulator are held stable by the caller.
module mac_arith
  import mac_pkg::*;
(
  input  wire logic [15:0] operand_a,
  input  wire logic [15:0] operand_b,
  input  wire logic [47:0] acc_in,
  input  wire mac_mode_t   mode,
  output mac_result_t      result
);

  // Extend to 50 bits so every sum is exact, then compare to 48 bits.
  logic [49:0] ext_a;
  logic [49:0] ext_b;
  logic [49:0] ext_acc;
  logic [49:0] product;
  logic [49:0] exact;

  assign ext_a   = mode.is_unsigned ? {34'h0, operand_a}
                                    : {{34{operand_a[15]}}, operand_a};
  assign ext_b   = mode.is_unsigned ? {34'h0, operand_b}
                                    : {{34{operand_b[15]}}, operand_b};
  assign ext_acc = mode.is_unsigned ? {2'h0, acc_in}
                                    : {{2{acc_in[47]}}, acc_in};
  assign product = 50'(ext_a * ext_b);

  // Operation select from subtract and accumulate bits (see RULE_02).
  always_comb begin
    unique case ({mode.subtract, mode.accumulate})
      2'b00:   exact = product;
      2'b01:   exact = 50'(ext_acc + product);
      2'b10:   exact = 50'(50'h0 - product);
      default: exact = 50'(ext_acc - product);
    endcase
  end

  // Overflow when the exact value leaves the 48-bit range (see RULE_20).
  assign result.acc      = exact[47:0];
  assign result.overflow = mode.is_unsigned ? (exact[49:48] != 2'h0)
                         : (exact[49:48] != {2{exact[47]}});

endmodule

// ===== src/mac_axil_slave.sv
// AXI4-Lite slave front end of the multiply/accumulate unit: turns bus
// transfers into one-cycle write and read strobes with a word index.
// Assumes one write and one read under way at a time.
module mac_axil_slave
  import mac_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  output logic             wr_strobe,
  output logic [3:0]       wr_index,
  output logic [15:0]      wr_data,
  output logic [1:0]       wr_lanes,
  output logic             rd_strobe,
  output logic [3:0]       rd_index,
  input  wire logic [15:0] rd_data
);

  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        rd_wait;
  logic        wr_go;
  logic        wr_hit;
  logic        rd_hit;

  // Address map check: index in range and no stray upper bits.
  function automatic logic mapped(input logic [7:0] addr);
    return (addr[7:6] == 2'h0) && (addr[5:2] <= MAC_IDX_LAST);
  endfunction

  assign wr_go    = aw_held && w_held && !s_axil_bvalid;
  assign wr_hit   = mapped(aw_addr);
  assign rd_hit   = mapped(s_axil_araddr);

  // Write channels: capture address and data in either order.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= 8'h00;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      s_axil_awready <= 1'b0;
      s_axil_wready  <= 1'b0;
      s_axil_bvalid  <= 1'b0;
      s_axil_bresp   <= MAC_RESP_OKAY;
      wr_strobe      <= 1'b0;
      wr_index       <= 4'h0;
      wr_data        <= 16'h0000;
      wr_lanes       <= 2'h0;
    end else begin
      s_axil_awready <= !aw_held && !s_axil_awready && s_axil_awvalid;
      s_axil_wready  <= !w_held && !s_axil_wready && s_axil_wvalid;
      if (s_axil_awvalid && s_axil_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_held <= 1'b1;
        w_data <= s_axil_wdata;
        w_strb <= s_axil_wstrb;
      end
      wr_strobe <= wr_go && wr_hit && (w_strb[1:0] != 2'h0);
      wr_index  <= aw_addr[5:2];
      wr_data   <= w_data[15:0];
      wr_lanes  <= w_strb[1:0];
      if (wr_go) begin
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= wr_hit ? MAC_RESP_OKAY : MAC_RESP_SLVERR;
      end else if (s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: register data two cycles after the address is taken, one cycle if unmapped.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid  <= 1'b0;
      s_axil_rdata   <= 32'h0000_0000;
      s_axil_rresp   <= MAC_RESP_OKAY;
      rd_wait        <= 1'b0;
      rd_strobe      <= 1'b0;
      rd_index       <= 4'h0;
    end else begin
      s_axil_arready <= !rd_wait && !s_axil_arready && !s_axil_rvalid
                        && s_axil_arvalid;
      rd_strobe      <= 1'b0;
      if (s_axil_arvalid && s_axil_arready) begin
        rd_wait      <= 1'b1;
        rd_strobe    <= rd_hit;
        rd_index     <= s_axil_araddr[5:2];
        s_axil_rresp <= rd_hit ? MAC_RESP_OKAY : MAC_RESP_SLVERR;
      end
      if (rd_wait && !rd_strobe) begin
        rd_wait       <= 1'b0;
        s_axil_rvalid <= 1'b1;
        s_axil_rdata  <= (s_axil_rresp == MAC_RESP_OKAY)
                         ? {16'h0000, rd_data} : 32'h0000_0000;
      end else if (s_axil_rvalid && s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ===== src/mac_pkg.sv
// Package for the multiply/accumulate unit: register map, control field
// positions, reset values, timing and the carrier structs.
// Assumes a 32-bit AXI4-Lite register bus with one register per word.
package mac_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [3:0] MAC_IDX_CONTROL   = 4'h0;
  localparam logic [3:0] MAC_IDX_OPERAND_A = 4'h1;
  localparam logic [3:0] MAC_IDX_OPERAND_B = 4'h2;
  localparam logic [3:0] MAC_IDX_ACC_HIGH  = 4'h3;
  localparam logic [3:0] MAC_IDX_ACC_MID   = 4'h4;
  localparam logic [3:0] MAC_IDX_ACC_LOW   = 4'h5;
  localparam logic [3:0] MAC_IDX_LAST      = 4'h5;

  // Control register field positions.
  localparam int MAC_BIT_SIGNED_SELECT   = 0;
  localparam int MAC_BIT_ACCUMULATE      = 1;
  localparam int MAC_BIT_SUBTRACT        = 2;
  localparam int MAC_BIT_SINGLE_TRIGGER  = 3;
  localparam int MAC_BIT_SQUARE          = 4;
  localparam int MAC_BIT_CLEAR_ALL       = 5;
  localparam int MAC_BIT_WRITE_INHIBIT   = 6;
  localparam int MAC_BIT_OVERFLOW        = 7;
  localparam int MAC_BIT_DIVIDE          = 8;

  // Reset values.
  localparam logic [15:0] MAC_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] MAC_DATA_RESET    = 16'h0000;

  // Cycles from trigger to accumulator update.
  localparam int MAC_LATENCY_CYCLES = 1;

  // AXI4-Lite response codes.
  localparam logic [1:0] MAC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MAC_RESP_SLVERR = 2'h2;

  // Operation settings handed to the arithmetic unit.
  typedef struct packed {
    logic is_unsigned;
    logic accumulate;
    logic subtract;
  } mac_mode_t;

  // Result of one operation.
  typedef struct packed {
    logic [47:0] acc;
    logic        overflow;
  } mac_result_t;

endpackage

// ===== src/mac_unit.sv
// Top of the multiply/accumulate unit: control register, operand and
// accumulator registers, trigger sequencing and the result path.
// Assumes an AXI4-Lite master on ref_clk, one transfer each way at a time.
//
// Contract
// (RULE_01) signed_select clear means signed, set unsigned.
// (RULE_02) Subtract/accumulate pick product, sum, negation, difference.
// (RULE_03) Accumulator is 48 bits; top bit signs.
// (RULE_04) Bits 7 and 15 read-only; control resets zero.
// (RULE_05) Two-operand mode starts after both operands written.
// (RULE_06) Single trigger starts on either operand write.
// (RULE_07) Single trigger ignored while squaring is enabled.
// (RULE_08) Square: one write loads both, starts square.
// (RULE_09) clear_all zeroes data, flag, sequence; self-clears.
// (RULE_10) clear_all aborts an operation in progress.
// (RULE_11) Writing zero to clear_all does nothing.
// (RULE_12) Write inhibit keeps accumulator unchanged.
// (RULE_13) overflow_flag set when last operation overflowed.
// (RULE_14) overflow_flag cleared on reset, start, clear_all.
// (RULE_15) Software never writes one to divide bit.
// (RULE_16) Control bits 15 to 9 read zero.
// (RULE_17) operand_a is 16-bit read/write, resets zero.
// (RULE_18) Operand loads start operation into the accumulator.
// (RULE_19) Result ready one clock after trigger.
// (RULE_20) Overflow when result exceeds 48-bit range.
module mac_unit
  import mac_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  output logic             op_in_progress,
  output logic             overflow_flag
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations.

  typedef enum logic [0:0] {
    MAC_IDLE,
    MAC_BUSY
  } mac_state_t;

  logic        wr_strobe;
  logic [3:0]  wr_index;
  logic [15:0] wr_data;
  logic [1:0]  wr_lanes;
  logic        rd_strobe;
  logic [3:0]  rd_index;
  logic [15:0] rd_data;

  logic [15:0] mult_control;
  logic [15:0] operand_a;
  logic [15:0] operand_b;
  logic [15:0] acc_high;
  logic [15:0] acc_mid;
  logic [15:0] acc_low;
  logic        seen_a;
  logic        seen_b;
  mac_state_t  state;
  logic        busy_overflow;

  logic [15:0] merged;
  logic        wr_ctrl;
  logic        wr_a;
  logic        wr_b;
  logic        wr_acc_high;
  logic        wr_acc_mid;
  logic        wr_acc_low;
  logic        clear_req;
  logic        square_on;
  logic        single_on;
  logic        operand_wr;
  logic        trigger;
  logic        next_seen_a;
  logic        next_seen_b;
  logic [15:0] next_control;
  logic [47:0] accumulator;
  mac_mode_t   mode;
  mac_result_t result;

  //////////////////////////////////////////////////////////////////////////
  // Bus front end and arithmetic core.

  // AXI4-Lite slave delivering write and read strobes.
  mac_axil_slave u_bus (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .wr_strobe      (wr_strobe),
    .wr_index       (wr_index),
    .wr_data        (wr_data),
    .wr_lanes       (wr_lanes),
    .rd_strobe      (rd_strobe),
    .rd_index       (rd_index),
    .rd_data        (rd_data)
  );

  // Operands are read from the registers as they stand in the busy cycle.
  mac_arith u_arith (
    .operand_a (operand_a),
    .operand_b (operand_b),
    .acc_in    (accumulator),
    .mode      (mode),
    .result    (result)
  );

  //////////////////////////////////////////////////////////////////////////
  // Write decode.

  // Byte lanes merge a partial write with the old register value.
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  lanes);
    return {lanes[1] ? new_v[15:8] : old_v[15:8],
            lanes[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  assign wr_ctrl     = wr_strobe && (wr_index == MAC_IDX_CONTROL);
  assign wr_a        = wr_strobe && (wr_index == MAC_IDX_OPERAND_A);
  assign wr_b        = wr_strobe && (wr_index == MAC_IDX_OPERAND_B);
  assign wr_acc_high = wr_strobe && (wr_index == MAC_IDX_ACC_HIGH);
  assign wr_acc_mid  = wr_strobe && (wr_index == MAC_IDX_ACC_MID);
  assign wr_acc_low  = wr_strobe && (wr_index == MAC_IDX_ACC_LOW);
  assign merged      = lane_merge(mult_control, wr_data, wr_lanes);

  // Only a written one starts a clear; a zero is no action (see RULE_11).
  assign clear_req   = wr_ctrl && merged[MAC_BIT_CLEAR_ALL]; // see RULE_09

  //////////////////////////////////////////////////////////////////////////
  // Trigger sequencing.

  // Squaring overrides the single-operand setting (see RULE_07).
  assign square_on  = mult_control[MAC_BIT_SQUARE];
  assign single_on  = mult_control[MAC_BIT_SINGLE_TRIGGER] && !square_on;
  assign operand_wr = (wr_a || wr_b) && !clear_req;

  // Sequence flags remember which operands were loaded (see RULE_05).
  assign next_seen_a = (seen_a || wr_a) && !trigger;
  assign next_seen_b = (seen_b || wr_b) && !trigger;

  // Start on one write when squaring or single (see RULE_06, RULE_08).
  assign trigger = operand_wr && (square_on || single_on
                   || ((seen_a || wr_a) && (seen_b || wr_b)));

  //////////////////////////////////////////////////////////////////////////
  // Control register next value.

  // Writable bits 14:8 and 6:0 of which only 8:0 exist (see RULE_04).
  always_comb begin
    next_control = mult_control;
    if (wr_ctrl) begin
      next_control[MAC_BIT_WRITE_INHIBIT:0] = merged[MAC_BIT_WRITE_INHIBIT:0];
      next_control[MAC_BIT_DIVIDE] = merged[MAC_BIT_DIVIDE]; // see RULE_15
    end
    next_control[15:9] = 7'h00;                             // see RULE_16
    next_control[MAC_BIT_CLEAR_ALL] = 1'b0;                 // see RULE_09
    if (clear_req || trigger) begin
      next_control[MAC_BIT_OVERFLOW] = 1'b0;                // see RULE_14
    end else if (state == MAC_BUSY) begin
      next_control[MAC_BIT_OVERFLOW] = busy_overflow;       // see RULE_13
    end
  end

  // Mode captured from the control register as it stands.
  assign mode.is_unsigned = mult_control[MAC_BIT_SIGNED_SELECT]; // see RULE_01
  assign mode.accumulate  = mult_control[MAC_BIT_ACCUMULATE];    // see RULE_18
  assign mode.subtract    = mult_control[MAC_BIT_SUBTRACT];      // see RULE_02
  assign accumulator      = {acc_high, acc_mid, acc_low};       // see RULE_03
  assign busy_overflow    = result.overflow;

  //////////////////////////////////////////////////////////////////////////
  // Registers.

  // Control register and sequence state.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mult_control <= MAC_CONTROL_RESET;                    // see RULE_04
      seen_a       <= 1'b0;
      seen_b       <= 1'b0;
    end else begin
      mult_control <= next_control;
      seen_a       <= clear_req ? 1'b0 : next_seen_a;       // see RULE_09
      seen_b       <= clear_req ? 1'b0 : next_seen_b;
    end
  end

  // Operation state: one busy cycle, aborted by a clear (see RULE_10).
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= MAC_IDLE;
    end else if (clear_req) begin
      state <= MAC_IDLE;
    end else begin
      state <= trigger ? MAC_BUSY : MAC_IDLE;               // see RULE_19
    end
  end

  // Operand registers; squaring loads both from one write (see RULE_08).
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      operand_a <= MAC_DATA_RESET;                          // see RULE_17
      operand_b <= MAC_DATA_RESET;
    end else if (clear_req) begin
      operand_a <= MAC_DATA_RESET;                          // see RULE_09
      operand_b <= MAC_DATA_RESET;
    end else if (wr_a) begin
      operand_a <= lane_merge(operand_a, wr_data, wr_lanes);
      if (square_on) begin
        operand_b <= lane_merge(operand_a, wr_data, wr_lanes);
      end
    end else if (wr_b) begin
      operand_b <= lane_merge(operand_b, wr_data, wr_lanes);
      if (square_on) begin
        operand_a <= lane_merge(operand_b, wr_data, wr_lanes);
      end
    end
  end

  // Accumulator words: clear, result, or software write.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_high <= MAC_DATA_RESET;
      acc_mid  <= MAC_DATA_RESET;
      acc_low  <= MAC_DATA_RESET;
    end else if (clear_req) begin
      acc_high <= MAC_DATA_RESET;                           // see RULE_09
      acc_mid  <= MAC_DATA_RESET;
      acc_low  <= MAC_DATA_RESET;
    end else if (state == MAC_BUSY
                 && !mult_control[MAC_BIT_WRITE_INHIBIT]) begin
      {acc_high, acc_mid, acc_low} <= result.acc;           // see RULE_12
    end else begin
      if (wr_acc_high) acc_high <= lane_merge(acc_high, wr_data, wr_lanes);
      if (wr_acc_mid)  acc_mid  <= lane_merge(acc_mid, wr_data, wr_lanes);
      if (wr_acc_low)  acc_low  <= lane_merge(acc_low, wr_data, wr_lanes);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Readback and status outputs.

  // Read mux; reserved control bits read zero (see RULE_16).
  always_comb begin
    unique case (rd_index)
      MAC_IDX_CONTROL:   rd_data = mult_control;
      MAC_IDX_OPERAND_A: rd_data = operand_a;
      MAC_IDX_OPERAND_B: rd_data = operand_b;
      MAC_IDX_ACC_HIGH:  rd_data = acc_high;
      MAC_IDX_ACC_MID:   rd_data = acc_mid;
      MAC_IDX_ACC_LOW:   rd_data = acc_low;
      default:           rd_data = 16'h0000;
    endcase
  end

  // Status outputs come straight from flip-flops.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_in_progress <= 1'b0;
      overflow_flag  <= 1'b0;
    end else begin
      op_in_progress <= trigger && !clear_req;
      overflow_flag  <= next_control[MAC_BIT_OVERFLOW];     // see RULE_13
    end
  end

endmodule

// ===== testbench/mac_host.sv
// Host model: AXI4-Lite master, one access at a time.
// Assumes calls right after a rising edge of ref_clk.
module mac_host (
  input  wire logic        ref_clk,
  output logic [7:0]       s_axil_awaddr,
  output logic             s_axil_awvalid,
  input  wire logic        s_axil_awready,
  output logic [31:0]      s_axil_wdata,
  output logic [3:0]       s_axil_wstrb,
  output logic             s_axil_wvalid,
  input  wire logic        s_axil_wready,
  input  wire logic        s_axil_bvalid,
  output logic             s_axil_bready,
  output logic [7:0]       s_axil_araddr,
  output logic             s_axil_arvalid,
  input  wire logic        s_axil_arready,
  input  wire logic        s_axil_rvalid,
  output logic             s_axil_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  int stall = 0; // Wait before taking an answer.

  // Idle bus at time zero.
  initial begin
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} = '0;
    {s_axil_arvalid, s_axil_rready, s_axil_awaddr, s_axil_araddr} = '0;
    s_axil_wdata = '0;
    s_axil_wstrb = 4'hF;
  end

  // Write: release each channel when taken.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    s_axil_awaddr  <= a;
    s_axil_wdata   <= {16'h0000, d};
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axil_awvalid && s_axil_awready) begin
        s_axil_awvalid <= 1'b0;
        s_axil_awaddr  <= ~a;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        s_axil_wvalid <= 1'b0;
        s_axil_wdata  <= ~s_axil_wdata;
      end
    end while (!s_axil_bvalid);
    repeat (stall) @(posedge ref_clk);
    s_axil_bready <= 1'b1;
    @(posedge ref_clk);
    s_axil_bready <= 1'b0;
  endtask

  // Read: hold the address until taken.
  task automatic rd(input logic [7:0] a);
    s_axil_araddr  <= a;
    s_axil_arvalid <= 1'b1;
    do @(posedge ref_clk); while (!s_axil_arready);
    s_axil_arvalid <= 1'b0;
    s_axil_araddr  <= ~a;
    while (!s_axil_rvalid) @(posedge ref_clk);
    repeat (stall) @(posedge ref_clk);
    s_axil_rready <= 1'b1;
    @(posedge ref_clk);
    s_axil_rready <= 1'b0;
  endtask
endmodule

// ===== testbench/mac_unit_monitor.sv
// Checker: bus answers and result timing.
// Assumes binding to mac_unit; sees only its ports.
module mac_unit_monitor
  import mac_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        s_axil_bvalid,
  input wire logic        s_axil_bready,
  input wire logic [1:0]  s_axil_bresp,
  input wire logic        s_axil_arvalid,
  input wire logic        s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic        s_axil_rvalid,
  input wire logic        s_axil_rready,
  input wire logic        op_in_progress,
  input wire logic        overflow_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Answers stand until taken; read data comes soon.
  AST_BVALID_HOLD:
    assert property (s_axil_bvalid && !s_axil_bready
      |=> s_axil_bvalid && $stable(s_axil_bresp)) else $error("B dropped");
  AST_RVALID_HOLD:
    assert property (s_axil_rvalid && !s_axil_rready
      |=> s_axil_rvalid && $stable(s_axil_rdata)) else $error("R dropped");
  AST_READ_SOON:
    assert property (s_axil_arvalid && s_axil_arready |-> ##[1:4]
      s_axil_rvalid) else $error("Late read.");
  AST_RDATA_UPPER:
    assert property (s_axil_rvalid |-> s_axil_rdata[31:16] == 16'h0000)
    else $error("Upper bits.");

  // One busy cycle per operation, only after a write.
  AST_BUSY_ONE:
    assert property (op_in_progress |=> !op_in_progress)
    else $error("Busy too long.");
  AST_BUSY_ON_WRITE:
    assert property (op_in_progress |-> s_axil_bvalid)
    else $error("Stray busy.");
  AST_FLAG_SET:
    assert property ($rose(overflow_flag) |->
      op_in_progress || $past(op_in_progress)) else $error("Stray flag.");
  AST_FLAG_CLEAR:
    assert property ($fell(overflow_flag) |-> op_in_progress ||
      $past(op_in_progress) || s_axil_bvalid) else $error("Flag lost.");

  // Main scenarios reached.
  cover property (op_in_progress);
  cover property ($rose(overflow_flag));
  cover property (s_axil_bvalid && s_axil_bresp == MAC_RESP_SLVERR);
endmodule

bind mac_unit mac_unit_monitor u_mon (.*);

// ===== testbench/tb_top.sv
// Bench: register model, reference arithmetic, scoreboard.
// Assumes mac_host as master and the bound checker.
module tb_top
  import mac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [3:0]  s_axil_wstrb;
  logic [1:0]  s_axil_bresp, s_axil_rresp;
  logic        s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic        s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
  logic        s_axil_rvalid, s_axil_rready, op_in_progress, overflow_flag;
  logic [15:0] m_ctl, m_a, m_b;
  logic [47:0] m_acc;
  logic        m_ovf, got_a, got_b;
  logic [33:0] rq[$];
  logic [1:0]  wq[$];
  int          mismatches = 0, cmp_count = 0, seed = 32'he85b;
  logic [15:0] modes[4] = '{16'h0008, 16'h0018, 16'h0010, 16'h0042};

  mac_unit dut (.*);
  mac_host host (.*);

  // Clock of 40 ns.
  always #20 ref_clk = ~ref_clk;

  //////////////////////////////////////////////////////////////////////////
  // Reference model of one operation.
  task automatic fire();
    longint p, c, r, hi;
    logic   u;
    u  = m_ctl[MAC_BIT_SIGNED_SELECT];
    p  = u ? longint'(m_a) * longint'(m_b)
           : longint'($signed(m_a)) * longint'($signed(m_b));
    c  = u ? longint'(m_acc) : longint'($signed(m_acc));
    hi = u ? 64'hFFFF_FFFF_FFFF : 64'h7FFF_FFFF_FFFF;
    case (m_ctl[2:1])
      2'b00: r = p;
      2'b01: r = c + p;
      2'b10: r = -p;
      default: r = c - p;
    endcase
    m_ovf = r > hi || r < (u ? 64'sh0 : -hi - 1);
    if (!m_ctl[MAC_BIT_WRITE_INHIBIT]) m_acc = r[47:0];
    got_a = 1'b0;
    got_b = 1'b0;
  endtask

  // Write through the host; the model follows.
  task automatic wreg(input logic [3:0] i, input logic [15:0] d);
    wq.push_back(i > MAC_IDX_LAST ? MAC_RESP_SLVERR : MAC_RESP_OKAY);
    host.stall = $random(seed) & 3;
    host.wr({2'b00, i, 2'b00}, d);
    case (i)
      4'h0: begin
        m_ctl = d & 16'h015F;
        if (d[MAC_BIT_CLEAR_ALL]) {m_a, m_b, m_acc, m_ovf, got_a, got_b} = '0;
      end
      4'h1, 4'h2: begin
        if (i == 4'h1 || m_ctl[4]) m_a = d;
        if (i == 4'h2 || m_ctl[4]) m_b = d;
        got_a = got_a | (i == 4'h1);
        got_b = got_b | (i == 4'h2);
        if (m_ctl[4] || m_ctl[3] || (got_a && got_b)) fire();
      end
      4'h3: m_acc[47:32] = d;
      4'h4: m_acc[31:16] = d;
      4'h5: m_acc[15:0] = d;
      default: ;
    endcase
  endtask

  // Read all registers and one unmapped word.
  task automatic chk_all();
    logic [15:0] e[7];
    e = '{{7'h00, m_ctl[8], m_ovf, m_ctl[6], 1'b0, m_ctl[4:0]},
          m_a, m_b, m_acc[47:32], m_acc[31:16], m_acc[15:0], 16'h0000};
    for (int i = 0; i < 7; i++) begin
      rq.push_back({i == 6 ? MAC_RESP_SLVERR : MAC_RESP_OKAY, 16'h0000, e[i]});
      host.stall = $random(seed) & 3;
      host.rd(8'(i * 4));
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Compare tasks.
  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t rd exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_wr(input logic [1:0] e, input logic [1:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t wr exp %h got %h", $time, e, g);
    end
  endtask

  // Each answer taken meets the oldest note.
  always @(posedge ref_clk) begin
    if (s_axil_rvalid && s_axil_rready)
      cmp_rd(rq.pop_front(), {s_axil_rresp, s_axil_rdata});
    if (s_axil_bvalid && s_axil_bready)
      cmp_wr(wq.pop_front(), s_axil_bresp);
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog cuts a hang short.
  initial begin
    repeat (30000) @(posedge ref_clk);
    mismatches++;
    stop_test();
  end

  // Main sequence.
  initial begin
    {m_ctl, m_a, m_b, m_acc, m_ovf, got_a, got_b} = '0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk_all();
    wreg(4'h0, 16'hFEDF);
    wreg(4'h6, 16'h1234);
    chk_all();
    for (int m = 0; m < 8; m++) begin
      wreg(4'h0, 16'(m));
      for (int k = 0; k < 2; k++) begin
        wreg(4'h1, k ? 16'($random(seed)) : 16'h8000);
        chk_all();
        wreg(4'h2, k ? 16'($random(seed)) : 16'hFFFF);
        chk_all();
      end
    end
    foreach (modes[j]) begin
      wreg(4'h0, modes[j]);
      wreg(4'h1, 16'($random(seed)));
      chk_all();
      wreg(4'h2, 16'($random(seed)));
      chk_all();
    end
    for (int r = 0; r < 2; r++) begin
      wreg(4'h0, 16'h0002);
      wreg(4'h3, 16'h7FFF);
      wreg(4'h4, 16'hFFFF);
      wreg(4'h5, 16'hFFFF);
      wreg(4'h1, 16'h0001);
      wreg(4'h2, 16'h0001);
      chk_all();
      wreg(4'h1, 16'h0003);
      wreg(4'h0, r ? 16'h0022 : 16'h0002);
      chk_all();
      wreg(4'h2, 16'h0005);
      chk_all();
    end
    @(posedge ref_clk);
    stop_test();
  end
endmodule
